/* brs_boot_reset_sequencer.sv */
`include "brs_regs.svh"

module brs_boot_reset_sequencer import brs_pkg::*; #(
  parameter int BOOT_CYCLES = `BRS_BOOT_CYCLES,
  parameter int SRST_CYCLES = `BRS_SRST_CYCLES
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // register port
  input  wire logic [7:0]   regAddr,
  input  wire logic         regWrEn,
  input  wire logic         regRdEn,
  input  wire logic [7:0]   regWrData,
  output logic     [7:0]    regRdData,
  output logic              regAck,
  // sample chain timing
  input  wire logic         accelPeriodEnd,
  input  wire logic         gyroPeriodEnd,
  // accelerometer chain control
  output logic              accelAntiAliasEn,
  output logic              accelLpfHalfRate,
  output logic              accelLpf700,
  output logic              accelUpdateEn,
  // gyroscope chain control
  output logic     [3:0]    gyroLpfRate,
  output logic              gyroLpfBypass,
  output logic              gyroUpdateEn,
  // trimming and pin
  output logic              trimReload,
  output logic              irqPinA
);

  localparam int MAXC = (BOOT_CYCLES > SRST_CYCLES) ? BOOT_CYCLES : SRST_CYCLES;
  localparam int CW   = $clog2(MAXC + 1);

  // refuse counts the sequencer cannot serve
  if (BOOT_CYCLES < 2 || SRST_CYCLES < 1) begin : gBadCounts
    $error("boot count needs two cycles and reset count one");
  end

  logic          rstMeta;
  logic          rstn;
  brs_state_type state;
  logic [CW-1:0] count;
  brs_byte_type  funcAccess;
  brs_byte_type  pinControl;
  brs_byte_type  irqRouteA;
  brs_byte_type  irqRouteB;
  brs_byte_type  ctrl [`BRS_CTRL_COUNT];
  brs_rate_type  accelRateEff;
  brs_rate_type  gyroRateEff;
  logic          accelLpEff;
  logic          gyroLpEff;
  logic          lastCycle;
  logic          bootDone;
  logic          srstDone;
  logic          access;
  logic          wrHit3;

  // true when an address falls in the control register group
  function automatic logic isCtrl(input logic [7:0] a);
    return (a >= `BRS_ADDR_CTRL_FIRST) && (a <= `BRS_ADDR_CTRL_LAST);
  endfunction

  // index of a control register
  function automatic int ctrlIdx(input logic [7:0] a);
    return int'(a - `BRS_ADDR_CTRL_FIRST);
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstn    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn    <= rstMeta;
    end
  end

  // request decode and procedure ends
  // RQ9: no access in boot
  assign access    = (regWrEn || regRdEn) && (state != S_POWERUP);
  assign lastCycle = (state == S_REBOOT) ? (count == CW'(BOOT_CYCLES - 1))
                                         : (count == CW'(SRST_CYCLES - 1));
  assign bootDone  = (state == S_REBOOT) && lastCycle;
  assign srstDone  = (state == S_SRESET) && lastCycle;
  assign wrHit3    = access && regWrEn
                     && (regAddr == `BRS_ADDR_CTRL_FIRST + 8'(`BRS_IDX_THIRD));

  // sequencer state and duration counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_POWERUP;
      count <= '0;
    end else begin
      case (state)
        // RQ7: bounded power-up boot
        S_POWERUP: begin
          if (count == CW'(BOOT_CYCLES - 1)) begin
            state <= S_IDLE;
            count <= '0;
          end else begin
            count <= count + CW'(1);
          end
        end
        S_IDLE: begin
          count <= '0;
          if (ctrl[`BRS_IDX_THIRD][`BRS_BOOT_BIT]) begin
            state <= S_REBOOT;
          end else if (ctrl[`BRS_IDX_THIRD][`BRS_SRST_BIT]) begin
            state <= S_SRESET;
          end
        end
        // RQ12: bounded soft reset
        S_REBOOT, S_SRESET: begin
          if (lastCycle) begin
            state <= S_IDLE;
            count <= '0;
          end else begin
            count <= count + CW'(1);
          end
        end
        default: begin
          state <= S_IDLE;
          count <= '0;
        end
      endcase
    end
  end

  // access select, pin control and routing registers
  // RQ11: defaults on soft reset end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      funcAccess <= `BRS_DEF_REG;
      pinControl <= `BRS_DEF_REG;
      irqRouteA  <= `BRS_DEF_REG;
      irqRouteB  <= `BRS_DEF_REG;
    end else begin
      // defaults first, a write to the same place in that cycle overrides
      if (srstDone) begin
        funcAccess <= `BRS_DEF_REG;
        pinControl <= `BRS_DEF_REG;
        irqRouteA  <= `BRS_DEF_REG;
        irqRouteB  <= `BRS_DEF_REG;
      end
      if (access && regWrEn) begin
        if (regAddr == `BRS_ADDR_FUNC_ACCESS) funcAccess <= regWrData;
        if (regAddr == `BRS_ADDR_PIN_CONTROL) pinControl <= regWrData;
        if (regAddr == `BRS_ADDR_IRQ_ROUTE_A) irqRouteA  <= regWrData;
        if (regAddr == `BRS_ADDR_IRQ_ROUTE_B) irqRouteB  <= regWrData;
      end
    end
  end

  // control registers, request bits self-clear, a set beats the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `BRS_CTRL_COUNT; i++) begin
        ctrl[i] <= `BRS_DEF_REG;
      end
    end else begin
      for (int i = 0; i < `BRS_CTRL_COUNT; i++) begin
        // RQ11: group restored
        if (srstDone) ctrl[i] <= `BRS_DEF_REG;
        if (access && regWrEn && isCtrl(regAddr) && ctrlIdx(regAddr) == i) begin
          ctrl[i] <= regWrData;
        end
      end
      // RQ14: reboot bit held
      if (state == S_REBOOT && !bootDone) begin
        ctrl[`BRS_IDX_THIRD][`BRS_BOOT_BIT] <= 1'b1;
      end else if (bootDone && !(wrHit3 && regWrData[`BRS_BOOT_BIT])) begin
        // RQ10: only the request bit changes
        ctrl[`BRS_IDX_THIRD][`BRS_BOOT_BIT] <= 1'b0;
      end
      // RQ13: soft reset bit held
      if (state == S_SRESET && !srstDone) begin
        ctrl[`BRS_IDX_THIRD][`BRS_SRST_BIT] <= 1'b1;
      end else if (srstDone) begin
        // RQ22: set wins over clear
        ctrl[`BRS_IDX_THIRD][`BRS_SRST_BIT] <= wrHit3 && regWrData[`BRS_SRST_BIT];
      end
    end
  end

  // register read port with one-cycle answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regAck    <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      regAck <= access;
      if (access && regRdEn) begin
        if (isCtrl(regAddr)) regRdData <= ctrl[ctrlIdx(regAddr)];
        else if (regAddr == `BRS_ADDR_FUNC_ACCESS) regRdData <= funcAccess;
        else if (regAddr == `BRS_ADDR_PIN_CONTROL) regRdData <= pinControl;
        else if (regAddr == `BRS_ADDR_IRQ_ROUTE_A) regRdData <= irqRouteA;
        else if (regAddr == `BRS_ADDR_IRQ_ROUTE_B) regRdData <= irqRouteB;
        else regRdData <= 8'h00; // unmapped reads zero
      end
    end
  end

  // accelerometer effective mode and filter controls
  // RQ4: change at period end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accelRateEff     <= `BRS_RATE_OFF;
      accelLpEff       <= 1'b0;
      accelAntiAliasEn <= 1'b0;
      accelLpfHalfRate <= 1'b0;
      accelLpf700      <= 1'b0;
      accelUpdateEn    <= 1'b0;
    end else if (accelPeriodEnd || accelRateEff == `BRS_RATE_OFF) begin
      accelRateEff <= ctrl[`BRS_IDX_ACCEL_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB];
      accelLpEff   <= ctrl[`BRS_IDX_ACCEL_MODE][`BRS_ACCEL_LP_BIT];
      // RQ21: power-down freezes output
      accelUpdateEn <= ctrl[`BRS_IDX_ACCEL_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB]
                       != `BRS_RATE_OFF;
      // RQ1: filter in high-performance
      accelAntiAliasEn <= (ctrl[`BRS_IDX_ACCEL_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB]
                           != `BRS_RATE_OFF) && !ctrl[`BRS_IDX_ACCEL_MODE][`BRS_ACCEL_LP_BIT];
      // RQ2: cutoff by mode
      accelLpfHalfRate <= (ctrl[`BRS_IDX_ACCEL_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB]
                           != `BRS_RATE_OFF) && !ctrl[`BRS_IDX_ACCEL_MODE][`BRS_ACCEL_LP_BIT];
      accelLpf700      <= (ctrl[`BRS_IDX_ACCEL_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB]
                           != `BRS_RATE_OFF) && ctrl[`BRS_IDX_ACCEL_MODE][`BRS_ACCEL_LP_BIT];
    end
  end

  // gyroscope effective mode and filter controls
  // RQ5: change at period end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gyroRateEff   <= `BRS_RATE_OFF;
      gyroLpEff     <= 1'b0;
      gyroLpfRate   <= `BRS_RATE_OFF;
      gyroLpfBypass <= 1'b0;
      gyroUpdateEn  <= 1'b0;
    end else if (gyroPeriodEnd || gyroRateEff == `BRS_RATE_OFF) begin
      gyroRateEff  <= ctrl[`BRS_IDX_GYRO_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB];
      gyroLpEff    <= ctrl[`BRS_IDX_GYRO_MODE][`BRS_GYRO_LP_BIT];
      gyroLpfRate  <= ctrl[`BRS_IDX_GYRO_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB];
      // RQ21: power-down freezes output
      gyroUpdateEn <= ctrl[`BRS_IDX_GYRO_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB]
                      != `BRS_RATE_OFF;
      // RQ3: bypass at top rate
      gyroLpfBypass <= ctrl[`BRS_IDX_GYRO_RATE][`BRS_RATE_MSB:`BRS_RATE_LSB]
                       == `BRS_RATE_6667;
    end
  end

  // trimming reload strobe and boot status on pin A
  // RQ15: boot status routed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trimReload <= 1'b0;
      irqPinA    <= 1'b0;
    end else begin
      trimReload <= (state == S_POWERUP && count != CW'(BOOT_CYCLES - 1))
                    || (state == S_REBOOT && !bootDone);
      irqPinA    <= ((state == S_POWERUP && count != CW'(BOOT_CYCLES - 1))
                    || (state == S_REBOOT && !bootDone))
                    && irqRouteA[`BRS_ROUTE_BOOT_BIT];
    end
  end

  // run-length counters read only by the checks below
  logic [CW:0] reloadRun;
  logic [CW:0] srstRun;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reloadRun <= '0;
      srstRun   <= '0;
    end else begin
      reloadRun <= trimReload ? reloadRun + (CW+1)'(1) : '0;
      srstRun   <= (state == S_SRESET) ? srstRun + (CW+1)'(1) : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_AAF_HP_ONLY: assert property ( // RQ1
    accelAntiAliasEn == (accelRateEff != `BRS_RATE_OFF && !accelLpEff))
    else $error("anti-alias filter on outside high-performance");
  AST_LPF_ONE_CUTOFF: assert property ( // RQ2
    accelUpdateEn |-> (accelLpfHalfRate ^ accelLpf700))
    else $error("accel low-pass cutoff not unique");
  AST_GYRO_BYPASS: assert property ( // RQ3
    gyroLpfBypass == (gyroLpfRate == `BRS_RATE_6667))
    else $error("gyro low-pass bypass wrong for rate");
  AST_ACCEL_PERIOD: assert property ( // RQ4
    accelUpdateEn && !accelPeriodEnd |=> $stable(accelLpf700) && $stable(accelLpfHalfRate))
    else $error("accel mode changed inside a period");
  AST_GYRO_PERIOD: assert property ( // RQ5
    gyroUpdateEn && !gyroPeriodEnd |=> $stable(gyroLpfRate) && $stable(gyroLpEff))
    else $error("gyro rate changed inside a period");
  AST_RELOAD_BOUND: assert property ( // RQ7
    reloadRun <= (CW+1)'(BOOT_CYCLES))
    else $error("trimming reload exceeds its bound");
  AST_PD_AFTER_BOOT: assert property ( // RQ8
    state == S_POWERUP ##1 state == S_IDLE |-> !accelUpdateEn && !gyroUpdateEn)
    else $error("sensor running after power-up boot");
  AST_NO_BOOT_ACCESS: assert property ( // RQ9
    state == S_POWERUP |=> !regAck)
    else $error("register access answered during boot");
  AST_REBOOT_KEEPS: assert property ( // RQ10
    state == S_REBOOT && !regWrEn |=> $stable(ctrl[`BRS_IDX_ACCEL_RATE]) && $stable(irqRouteA))
    else $error("reboot altered control registers");
  AST_SRST_DEFAULTS: assert property ( // RQ11
    srstDone && !regWrEn |=> funcAccess == `BRS_DEF_REG && irqRouteB == `BRS_DEF_REG
      && ctrl[`BRS_IDX_GYRO_RATE] == `BRS_DEF_REG)
    else $error("soft reset left a register off default");
  AST_SRST_BOUND: assert property ( // RQ12
    srstRun <= (CW+1)'(SRST_CYCLES))
    else $error("soft reset exceeds its bound");
  AST_SRST_BIT: assert property ( // RQ13
    state == S_SRESET |-> ctrl[`BRS_IDX_THIRD][`BRS_SRST_BIT])
    else $error("soft reset bit low while running");
  AST_BOOT_BIT: assert property ( // RQ14
    $rose(state == S_REBOOT) |-> ctrl[`BRS_IDX_THIRD][`BRS_BOOT_BIT] [*2])
    else $error("reboot bit low while reloading");
  AST_PIN_A: assert property ( // RQ15
    irqPinA |-> trimReload && $past(irqRouteA[`BRS_ROUTE_BOOT_BIT]))
    else $error("pin A high outside routed boot");

  COV_REBOOT: cover property (bootDone ##1 state == S_IDLE);
  COV_SRESET: cover property (srstDone ##1 state == S_IDLE);
  COV_PIN_A: cover property ($fell(irqPinA));
  COV_ACCEL_LP: cover property ($rose(accelLpf700));

endmodule

/* brs_regs.svh */
`ifndef BRS_REGS_SVH
`define BRS_REGS_SVH
// Behaviour
// RQ1: anti-aliasing filter on only in accelerometer high-performance mode.
// RQ2: accel low-pass cutoff is rate/2 in high-performance, 700 Hz in low-power.
// RQ3: gyro low-pass follows gyro rate, bypassed at 6667 Hz.
// RQ4: accel mode change applies only after current sample period ends.
// RQ5: gyro mode change applies only after current sample period ends.
// RQ6: host discards first samples after accel mode or rate change.
// RQ7: power-up boot loads trimming and finishes within 10 ms.
// RQ8: after power-up boot both sensors are in power-down.
// RQ9: no register access during boot; host does not rely on it.
// RQ10: reboot bit reloads trimming, control registers stay unchanged.
// RQ11: soft reset restores 01h, 02h, both routing registers, 10h to 19h.
// RQ12: soft reset completes within 50 us.
// RQ13: soft reset bit reads one while running, clears itself when done.
// RQ14: reboot bit reads one while reload runs, clears itself when done.
// RQ15: with boot routing set, pin A is high during boot, low after.
// RQ16: host powers down both sensors before reboot or soft reset.
// RQ17: host waits 10 ms, watches pin A, or polls the reboot bit.
// RQ18: host waits 50 us or polls soft reset bit until zero.
// RQ19: host never sets reboot and soft reset together; runs them serially.
// RQ20: host writes a non power-down accel rate to start acquisition.
// RQ21: in power-down configuration is kept and output data stops updating.
// RQ22: request bits self-clear at their own procedure end only; the soft reset end also clears a set reboot bit.

// register offsets
`define BRS_ADDR_FUNC_ACCESS 8'h01
`define BRS_ADDR_PIN_CONTROL 8'h02
`define BRS_ADDR_IRQ_ROUTE_A 8'h0D
`define BRS_ADDR_IRQ_ROUTE_B 8'h0E
`define BRS_ADDR_CTRL_FIRST  8'h10
`define BRS_ADDR_CTRL_LAST   8'h19
`define BRS_CTRL_COUNT       10
// control register indices from the first control register
`define BRS_IDX_ACCEL_RATE   0
`define BRS_IDX_GYRO_RATE    1
`define BRS_IDX_THIRD        2
`define BRS_IDX_ACCEL_MODE   5
`define BRS_IDX_GYRO_MODE    6
// field positions
`define BRS_RATE_MSB         7
`define BRS_RATE_LSB         4
`define BRS_BOOT_BIT         7
`define BRS_SRST_BIT         0
`define BRS_ACCEL_LP_BIT     4
`define BRS_GYRO_LP_BIT      7
`define BRS_ROUTE_BOOT_BIT   2
// rate codes
`define BRS_RATE_OFF         4'h0
`define BRS_RATE_6667        4'hA
// reset values
`define BRS_DEF_REG          8'h00
// timing
`define BRS_CLK_MHZ          250
`define BRS_BOOT_MAX_MS      10
`define BRS_SRST_MAX_US      50
`define BRS_BOOT_CYCLES      (`BRS_BOOT_MAX_MS * 1000 * `BRS_CLK_MHZ)
`define BRS_SRST_CYCLES      (`BRS_SRST_MAX_US * `BRS_CLK_MHZ)
`endif

/* brs_pkg.sv */
package brs_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    S_POWERUP,
    S_IDLE,
    S_REBOOT,
    S_SRESET
  } brs_state_type;
  typedef logic [3:0] brs_rate_type;
  typedef logic [7:0] brs_byte_type;
endpackage

/* brs_host_model.sv */
module brs_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData,
  input  wire logic       regAck,
  // sample period marks
  output logic            accelPeriodEnd,
  output logic            gyroPeriodEnd
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    regAddr = 8'hFF;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 8'hFF;
    accelPeriodEnd = 1'b0;
    gyroPeriodEnd = 1'b0;
  end

  // one access: drive after an edge, taken at the next, answer read 1 ns after that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(posedge clk);
    regAddr <= a;
    regWrEn <= w;
    regRdEn <= ~w;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    regAddr <= ~a;      // released lines do not keep the old value
    regWrData <= ~d;
    #1;
    ok = regAck;
    q = regRdData;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q, output int tries);
    logic ok;
    tries = 0;
    ok = 1'b0;
    while (ok !== 1'b1 && tries < 64) begin
      xfer(1'b0, a, 8'h00, q, ok);
      tries++;
    end
  endtask

  // plain write, answer not needed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       ok;
    xfer(1'b1, a, d, q, ok);
  endtask

  // one-cycle end-of-period marks for the sample chains
  task automatic mark(input logic a, input logic g);
    @(posedge clk);
    accelPeriodEnd <= a;
    gyroPeriodEnd <= g;
    @(posedge clk);
    accelPeriodEnd <= 1'b0;
    gyroPeriodEnd <= 1'b0;
  endtask
endmodule

/* boot_reset_sequencer_bench.sv */
module boot_reset_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BOOT = 20;
  localparam int SRST = 10;

  logic       clk, resetn, regWrEn, regRdEn, regAck, accelPeriodEnd, gyroPeriodEnd;
  logic       accelAntiAliasEn, accelLpfHalfRate, accelLpf700, accelUpdateEn;
  logic       gyroLpfBypass, gyroUpdateEn, trimReload, irqPinA;
  logic [7:0] regAddr, regWrData, regRdData, q;
  logic [3:0] gyroLpfRate;
  logic [3:0] accelView;
  int         miscompares, comparisons, t, n;
  logic [7:0] addrList [15] = '{8'h01, 8'h02, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h03};

  // accel filter controls seen together
  assign accelView = {accelAntiAliasEn, accelLpfHalfRate, accelLpf700, accelUpdateEn};

  // clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  brs_boot_reset_sequencer #(.BOOT_CYCLES(BOOT), .SRST_CYCLES(SRST)) u_dut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .regAck(regAck), .accelPeriodEnd(accelPeriodEnd), .gyroPeriodEnd(gyroPeriodEnd),
    .accelAntiAliasEn(accelAntiAliasEn), .accelLpfHalfRate(accelLpfHalfRate),
    .accelLpf700(accelLpf700), .accelUpdateEn(accelUpdateEn),
    .gyroLpfRate(gyroLpfRate), .gyroLpfBypass(gyroLpfBypass),
    .gyroUpdateEn(gyroUpdateEn), .trimReload(trimReload), .irqPinA(irqPinA));

  brs_host_model u_host (
    .clk(clk), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regWrData(regWrData), .regRdData(regRdData), .regAck(regAck),
    .accelPeriodEnd(accelPeriodEnd), .gyroPeriodEnd(gyroPeriodEnd));

  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // let edges land before sampling levels
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // write every mapped register and the unmapped one
  task automatic fillAll(input logic [7:0] d);
    foreach (addrList[i]) begin
      u_host.wr(addrList[i], d);
    end
  endtask

  // read all back, the unmapped place always reads zero
  task automatic checkAll(input logic [7:0] exp);
    foreach (addrList[i]) begin
      u_host.rd(addrList[i], q, t);
      chk("register", q, (i == 14) ? 8'h00 : exp);
    end
  endtask

  // poll the request register until the masked bit clears
  task automatic poll(input logic [7:0] msk);
    n = 0;
    q = msk;
    while ((q & msk) !== 8'h00 && n < 30) begin
      u_host.rd(8'h12, q, t);
      n++;
    end
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    cyc(5);
    chk("trim in boot", {7'h0, trimReload}, 8'h01);
    u_host.rd(8'h10, q, t);
    chk("boot refused", {7'h0, t > 1}, 8'h01);
    chk("boot length", {7'h0, t <= 12}, 8'h01);
    chk("trim done", {7'h0, trimReload}, 8'h00);
    chk("sensors off", {6'h0, accelUpdateEn, gyroUpdateEn}, 8'h00);
    checkAll(8'h00);
    // accel high-performance, then low-power held to period end
    u_host.wr(8'h10, 8'h40);
    cyc(2);
    chk("accel hp", {4'h0, accelView}, 8'h0D);
    u_host.wr(8'h15, 8'h10);
    cyc(3);
    chk("accel held", {4'h0, accelView}, 8'h0D);
    u_host.mark(1'b1, 1'b0);
    cyc(2);
    chk("accel lp", {4'h0, accelView}, 8'h03);
    // gyro fastest rate bypasses, slower rate held to period end
    u_host.wr(8'h11, 8'hA0);
    cyc(2);
    chk("gyro fast", {gyroLpfBypass, gyroUpdateEn, 2'b00, gyroLpfRate}, 8'hCA);
    u_host.wr(8'h11, 8'h30);
    cyc(3);
    chk("gyro held", {gyroLpfBypass, gyroUpdateEn, 2'b00, gyroLpfRate}, 8'hCA);
    u_host.mark(1'b0, 1'b1);
    cyc(2);
    chk("gyro slow", {gyroLpfBypass, gyroUpdateEn, 2'b00, gyroLpfRate}, 8'h43);
    // power down both before any reset request
    fillAll(8'h0C);
    cyc(2);
    chk("off held", {6'h0, accelUpdateEn, gyroUpdateEn}, 8'h03);
    u_host.mark(1'b1, 1'b1);
    cyc(2);
    chk("off frozen", {6'h0, accelUpdateEn, gyroUpdateEn}, 8'h00);
    checkAll(8'h0C);
    u_host.wr(8'h12, 8'h8C);
    cyc(2);
    chk("reload", {6'h0, trimReload, irqPinA}, 8'h03);
    u_host.rd(8'h12, q, t);
    chk("boot bit", q, 8'h8C);
    poll(8'h80);
    chk("reboot time", {7'h0, n <= 9}, 8'h01);
    cyc(2);
    chk("pin low", {6'h0, trimReload, irqPinA}, 8'h00);
    checkAll(8'h0C);
    // soft reset alone after the reboot finished
    u_host.wr(8'h12, 8'h0D);
    u_host.rd(8'h12, q, t);
    chk("reset bit", q, 8'h0D);
    poll(8'h01);
    chk("reset time", {7'h0, n <= 5}, 8'h01);
    checkAll(8'h00);
    close_out();
  end
endmodule
